// ==== src/host_port_pkg.sv ====
/*
 * Shared constants for the parallel host port and its controller.
 * Assumes a single 20 MHz clock shared by both ends and by software.
 */
package host_port_pkg;

	// Word address of the host interrupt control register.
	localparam logic [7:0]  INT_CTRL_ADDR   = 8'h0F;
	// Position of the interrupt request flag in that register.
	localparam int          INT_REQ_BIT     = 9;
	localparam logic [15:0] INT_CTRL_RESET  = 16'h0000;
	// Mask applied by the controller when it rewrites the flag.
	localparam logic [15:0] INT_KEEP_MASK   = 16'hFDFF;

	// Controller register byte offsets on AXI4-Lite.
	localparam logic [4:0]  CTL_OFS         = 5'h00;
	localparam logic [4:0]  ADDR_OFS        = 5'h04;
	localparam logic [4:0]  WDATA_OFS       = 5'h08;
	localparam logic [4:0]  RDATA_OFS       = 5'h0C;
	localparam logic [4:0]  STAT_OFS        = 5'h10;
	localparam logic [4:0]  IRQ_STAT_OFS    = 5'h14;
	localparam logic [4:0]  IRQ_MASK_OFS    = 5'h18;

	// Control register bit positions.
	localparam int          CTL_GO_BIT      = 0;
	localparam int          CTL_WRITE_BIT   = 1;
	localparam int          CTL_LOWSEL_BIT  = 2;
	localparam int          CTL_IRQSET_BIT  = 3;
	localparam int          CTL_IRQCLR_BIT  = 4;

	// Cycles the device waits before it drives the acknowledge strobe low.
	localparam int          ACCESS_CYCLES   = 2;
	// Extra cycles the controller waits after seeing the strobe.
	localparam int          UPPER_WAIT      = 1;

endpackage : host_port_pkg

// ==== src/host_port_if.sv ====
/*
 * Parallel host port wires between the external controller and the
 * decoder's port. Both ends run on the same system clock.
 */
`timescale 1ns/100ps
interface host_port_if;
	logic        select;        // Access request, high for the whole access.
	logic        rw_sel;        // Read/write select, polarity by revision.
	logic [7:0]  word_addr;     // 16-bit word address.
	logic [15:0] wdata;         // Data from controller.
	logic [15:0] rdata;         // Data from device.
	logic        transfer_acknowledge_strobe_n; // Low acknowledges.

	modport device (input select, input rw_sel, input word_addr,
		input wdata, output rdata, output transfer_acknowledge_strobe_n);
	modport host (output select, output rw_sel, output word_addr,
		output wdata, input rdata, input transfer_acknowledge_strobe_n);
endinterface : host_port_if

// ==== src/host_port_device.sv ====
/*
 * Decoder end of the parallel host port: 16-bit word register access.
 * Assumes the controller holds select high for the whole access.
 */
`timescale 1ns/100ps
module host_port_device
	import host_port_pkg::*;
(
	// Clock and reset.
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Link.
	host_port_if.device      port,
	// User side.
	input  wire logic        host_port_enable,
	input  wire logic        rw_low_write,
	input  wire logic        irq_event,
	output logic             irq_request,
	output logic [15:0]      int_ctrl_value
);
	logic [15:0] int_ctrl_reg;
	logic [15:0] regs_reg [0:15];
	logic [1:0]  wait_reg;
	logic        ack_reg;
	logic [15:0] rdata_reg;
	logic        is_write;

	// Second revision reads the select as active low.
	assign is_write = rw_low_write ? ~port.rw_sel : port.rw_sel;

	// Access sequencing, honoured only while the port is enabled.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wait_reg  <= 2'h0;
			ack_reg   <= 1'b0;
			rdata_reg <= 16'h0000;
		end else if (!port.select || !host_port_enable) begin
			wait_reg <= 2'h0;
			ack_reg  <= 1'b0; // Released when the cycle ends.
		end else if (!ack_reg) begin
			if (wait_reg == 2'(ACCESS_CYCLES)) begin
				ack_reg <= 1'b1; // Strobe low with the last data load.
			end else begin
				wait_reg <= wait_reg + 2'h1;
			end
			if (port.word_addr == INT_CTRL_ADDR)
				rdata_reg <= int_ctrl_reg;
			else
				rdata_reg <= regs_reg[port.word_addr[3:0]];
		end
	end

	// Register writes happen once, on the acknowledge.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_ctrl_reg <= INT_CTRL_RESET;
		end else begin
			if (port.select && host_port_enable && is_write &&
				wait_reg == 2'(ACCESS_CYCLES) && !ack_reg &&
				port.word_addr == INT_CTRL_ADDR)
				int_ctrl_reg <= port.wdata; // Full word only.
			if (irq_event)
				int_ctrl_reg[INT_REQ_BIT] <= 1'b1; // Event wins.
		end
	end

	// Plain storage for the other words.
	always_ff @(posedge aclk) begin
		if (port.select && host_port_enable && is_write &&
			wait_reg == 2'(ACCESS_CYCLES) && !ack_reg &&
			port.word_addr != INT_CTRL_ADDR)
			regs_reg[port.word_addr[3:0]] <= port.wdata;
	end

	assign port.rdata = rdata_reg;
	assign port.transfer_acknowledge_strobe_n = ~ack_reg;
	assign irq_request    = int_ctrl_reg[INT_REQ_BIT];
	assign int_ctrl_value = int_ctrl_reg;
endmodule : host_port_device

// ==== src/host_port_ctrl.sv ====
/*
 * Controller end of the host port, driven from AXI4-Lite registers.
 * Assumes one clock shared with the device.
 */
// Chosen here: the AXI4-Lite interface to the registers.
// What this block does
// - Device acknowledges read data with strobe low
// - Select polarity follows silicon revision
// - Strobe passes a flip-flop before use
// - Wait a little after strobe before capture
// - Port works only with enable set
// - Interrupt request is bit 9 of 0x0F
// - Change flag by read, mask, write back
// - All accesses are full 16-bit words
// - Word addresses; software writes them as is, no halving
`timescale 1ns/100ps
module host_port_ctrl
	import host_port_pkg::*;
(
	// Clock and reset.
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite slave.
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [4:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Link.
	host_port_if.host        port,
	// Interrupt.
	output logic             irq
);
	typedef enum logic [5:0] {
		IDLE   = 6'b000001,
		ACCESS = 6'b000010,
		SETTLE = 6'b000100,
		GAP    = 6'b001000,
		MODIFY = 6'b010000,
		DONE   = 6'b100000
	} state_t;

	state_t      state_reg;
	logic [4:0]  ctl_reg;
	logic [7:0]  addr_reg;
	logic [15:0] wdata_reg;
	logic [15:0] rdata_reg;
	logic [1:0]  irq_stat_reg;
	logic [1:0]  irq_mask_reg;
	logic        ack_sync_reg;
	logic        rmw_reg;
	logic        write_reg;
	logic        aw_done_reg;
	logic        w_done_reg;
	logic [4:0]  aw_addr_reg;
	logic [31:0] w_data_reg;
	logic        wr_fire;
	logic        busy;
	logic        done_evt;
	logic        irq_evt;

	// Offset compare used by the write decode.
	function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
		hit = (a == o);
	endfunction : hit

	assign busy = (state_reg != IDLE);

	// Write address and data are taken independently.
	assign s_axi_awready = !aw_done_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_done_reg && !s_axi_bvalid;
	assign wr_fire       = aw_done_reg && w_done_reg && !s_axi_bvalid;
	assign s_axi_bresp   = 2'h0;
	assign s_axi_rresp   = 2'h0;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_done_reg  <= 1'b0;
			w_done_reg   <= 1'b0;
			aw_addr_reg  <= 5'h00;
			w_data_reg   <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_done_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_done_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
			end
			if (wr_fire) begin
				aw_done_reg  <= 1'b0;
				w_done_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read answer one cycle after the address is taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			case (s_axi_araddr)
				CTL_OFS:      s_axi_rdata <= {27'h0, ctl_reg};
				ADDR_OFS:     s_axi_rdata <= {24'h0, addr_reg};
				WDATA_OFS:    s_axi_rdata <= {16'h0, wdata_reg};
				RDATA_OFS:    s_axi_rdata <= {16'h0, rdata_reg};
				STAT_OFS:     s_axi_rdata <= {31'h0, busy};
				IRQ_STAT_OFS: s_axi_rdata <= {30'h0, irq_stat_reg};
				IRQ_MASK_OFS: s_axi_rdata <= {30'h0, irq_mask_reg};
				default:      s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Software registers; the go bit clears itself once taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl_reg      <= 5'h00;
			addr_reg     <= 8'h00;
			wdata_reg    <= 16'h0000;
			irq_mask_reg <= 2'h0;
		end else begin
			if (wr_fire && hit(aw_addr_reg, CTL_OFS))
				ctl_reg <= w_data_reg[4:0];
			else if (state_reg == IDLE)
				ctl_reg[CTL_GO_BIT] <= 1'b0;
			if (wr_fire && hit(aw_addr_reg, ADDR_OFS))
				addr_reg <= w_data_reg[7:0]; // Word address.
			if (wr_fire && hit(aw_addr_reg, WDATA_OFS))
				wdata_reg <= w_data_reg[15:0];
			if (wr_fire && hit(aw_addr_reg, IRQ_MASK_OFS))
				irq_mask_reg <= w_data_reg[1:0];
		end
	end

	// Acknowledge is retimed through one flip-flop before use.
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ack_sync_reg <= 1'b0;
		else
			ack_sync_reg <= ~port.transfer_acknowledge_strobe_n;
	end

	// Access sequencer, with read-modify-write for the request flag.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= IDLE;
			rmw_reg   <= 1'b0;
			write_reg <= 1'b0;
			rdata_reg <= 16'h0000;
		end else begin
			case (state_reg)
				IDLE: if (ctl_reg[CTL_GO_BIT]) begin
					rmw_reg   <= ctl_reg[CTL_IRQSET_BIT] |
						ctl_reg[CTL_IRQCLR_BIT];
					// A flag change begins with a read.
					write_reg <= ctl_reg[CTL_WRITE_BIT] &
						~(ctl_reg[CTL_IRQSET_BIT] |
						ctl_reg[CTL_IRQCLR_BIT]);
					state_reg <= ACCESS;
				end
				ACCESS: if (ack_sync_reg)
					state_reg <= SETTLE;
				SETTLE: begin
					rdata_reg <= port.rdata; // After extra wait.
					state_reg <= GAP;
				end
				GAP: if (!ack_sync_reg) // Strobe released.
					state_reg <= rmw_reg ? MODIFY : DONE;
				MODIFY: begin
					rmw_reg   <= 1'b0;
					write_reg <= 1'b1;
					state_reg <= ACCESS;
				end
				DONE: state_reg <= IDLE;
				default: state_reg <= IDLE;
			endcase
		end
	end

	// Link outputs; writes of the flag keep the other bits.
	always_comb begin
		port.select    = (state_reg == ACCESS) || (state_reg == SETTLE);
		port.word_addr = rmw_reg || write_reg && ctl_reg[CTL_IRQSET_BIT] ?
			INT_CTRL_ADDR : addr_reg;
		port.wdata     = wdata_reg;
		if (write_reg && (ctl_reg[CTL_IRQSET_BIT] ||
			ctl_reg[CTL_IRQCLR_BIT])) begin
			port.word_addr = INT_CTRL_ADDR;
			port.wdata = (rdata_reg & INT_KEEP_MASK) |
				(16'(ctl_reg[CTL_IRQSET_BIT]) << INT_REQ_BIT);
		end
		// Drive the select with the polarity of the revision.
		port.rw_sel = ctl_reg[CTL_LOWSEL_BIT] ? ~write_reg : write_reg;
	end

	assign done_evt = (state_reg == DONE);
	// The flag is judged on the live read word, as the copy lags a cycle.
	assign irq_evt  = (state_reg == SETTLE) && !write_reg &&
		(port.word_addr == INT_CTRL_ADDR) && port.rdata[INT_REQ_BIT];

	// Sticky events: set wins over a write-one clear.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_reg <= 2'h0;
		end else begin
			if (wr_fire && hit(aw_addr_reg, IRQ_STAT_OFS))
				irq_stat_reg <= irq_stat_reg & ~w_data_reg[1:0];
			if (done_evt)
				irq_stat_reg[0] <= 1'b1;
			if (irq_evt)
				irq_stat_reg[1] <= 1'b1;
		end
	end

	assign irq = |(irq_stat_reg & irq_mask_reg);
endmodule : host_port_ctrl

// ==== tb/host_port_props.sv ====
/*
 * Checker for the host port wires between controller and device.
 * Assumes one clock and the port enable as a plain input.
 */
`timescale 1ns/100ps
module host_port_props (
	// Clock and reset.
	input wire logic        aclk,
	input wire logic        aresetn,
	// Port wires.
	input wire logic        select,
	input wire logic        rw_sel,
	input wire logic [7:0]  word_addr,
	input wire logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic        transfer_acknowledge_strobe_n,
	input wire logic        host_port_enable
);
	wire ack = !transfer_acknowledge_strobe_n;

	// All checks share the single clock domain.
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_ack_latency: assert property (
		$rose(select) && host_port_enable |-> ##[2:4] ack)
		else $error("acknowledge late");
	a_ack_in_cycle: assert property (
		$fell(transfer_acknowledge_strobe_n) |-> select)
		else $error("acknowledge outside access");
	a_rdata_steady: assert property (ack |-> $stable(rdata))
		else $error("read data moved under acknowledge");
	a_no_ack_off: assert property (
		!host_port_enable && $rose(select) |->
		transfer_acknowledge_strobe_n [*6])
		else $error("ack while off");
	a_ack_held: assert property (ack && select |=> ack)
		else $error("acknowledge dropped early");
	a_ack_release: assert property ($fell(select) |=> !ack)
		else $error("acknowledge not released");
	a_idle_first: assert property ($rose(select) |-> !ack)
		else $error("access began under acknowledge");
	a_word_steady: assert property (
		select && !ack |=> select && $stable({rw_sel, word_addr, wdata}))
		else $error("request moved");
	a_capture_bound: assert property (ack |-> ##[1:4] !select)
		else $error("controller never took the word");
endmodule : host_port_props

// ==== tb/host_port_handshake_tb.sv ====
/*
 * Bench for controller and device joined by the host port.
 * Assumes the register map and timing in the shared package.
 */
`timescale 1ns/100ps
module host_port_handshake_tb
	import host_port_pkg::*;
;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic [4:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, v;
	logic [1:0]  bresp, rresp;
	logic        enable, rw_low, irq_event, irq_request, seen_rw;
	logic [15:0] int_val;
	int          n_errors, n_checks, r;
	host_port_if port ();

	host_port_device host_port_device_i (.aclk(aclk), .aresetn(aresetn),
		.port(port), .host_port_enable(enable), .rw_low_write(rw_low),
		.irq_event(irq_event), .irq_request(irq_request),
		.int_ctrl_value(int_val));
	host_port_ctrl host_port_ctrl_i (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .port(port), .irq(irq));
	host_port_props host_port_props_i (.aclk(aclk), .aresetn(aresetn),
		.select(port.select), .rw_sel(port.rw_sel),
		.word_addr(port.word_addr), .wdata(port.wdata), .rdata(port.rdata),
		.transfer_acknowledge_strobe_n(port.transfer_acknowledge_strobe_n),
		.host_port_enable(enable));

	always #25 aclk = ~aclk;

	// Remember the select polarity of the latest access.
	always @(posedge aclk) if (port.select === 1'b1) seen_rw <= port.rw_sel;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Ready is sampled at the rising edge that completes the handshake.
	task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
		logic aw_p, w_p;
		aw_p = 1;
		w_p = 1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		while (aw_p || w_p) begin
			@(posedge aclk);
			if (awready)
				aw_p = 0;
			if (wready)
				w_p = 0;
			awvalid <= aw_p;
			wvalid <= w_p;
		end
		bready <= 1;
		do @(posedge aclk); while (!bvalid);
		bready <= 0;
		chk(bresp, 32'h0);
	endtask : axi_wr

	// The answer is taken at the edge where rvalid is seen high.
	task automatic axi_rd(input logic [4:0] a, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1;
		do @(posedge aclk); while (!arready);
		arvalid <= 0;
		rready <= 1;
		do @(posedge aclk); while (!rvalid);
		d = rdata;
		rready <= 0;
		chk(rresp, 32'h0);
	endtask : axi_rd

	// One port access, then wait for busy to clear under a bound.
	task automatic op(input logic [4:0] c, input logic [7:0] a,
		input logic [15:0] d);
		logic [31:0] s;
		axi_wr(ADDR_OFS, {24'h0, a});
		axi_wr(WDATA_OFS, {16'h0, d});
		axi_wr(CTL_OFS, {27'h0, c} | (32'(rw_low) << CTL_LOWSEL_BIT));
		for (int i = 0; i < 40; i++) begin
			axi_rd(STAT_OFS, s);
			if (s[0] === 1'b0) break;
		end
		chk(s, 32'h0);
	endtask : op

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish

	// A full run needs well under 500 cycles; the 10000-cycle limit leaves wide margin.
	initial begin
		#500us;
		n_errors++;
		tally_and_finish;
	end

	initial begin
		aclk = 0;
		aresetn = 0;
		enable = 1;
		rw_low = 0;
		irq_event = 0;
		awvalid = 0;
		wvalid = 0;
		bready = 0;
		arvalid = 0;
		rready = 0;
		awaddr = 0;
		araddr = 0;
		wdata = 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		chk(int_val, INT_CTRL_RESET);
		// Both select polarities, write then read back.
		for (r = 0; r < 2; r++) begin
			rw_low <= r[0];
			@(posedge aclk);
			op(5'h03, 8'h03, 16'hA5C3 ^ r[15:0]);
			chk(seen_rw, !r[0]);
			op(5'h01, 8'h03, 16'h0);
			chk(seen_rw, r[0]);
			axi_rd(RDATA_OFS, v);
			chk(v, 32'hA5C3 ^ r);
		end
		irq_event <= 1;
		@(posedge aclk);
		irq_event <= 0;
		repeat (2) @(posedge aclk);
		chk(irq_request, 1);
		axi_rd(IRQ_STAT_OFS, v);
		chk(v, 32'h1);
		op(5'h01, INT_CTRL_ADDR, 16'h0);
		axi_rd(RDATA_OFS, v);
		chk(v, 32'h0200);
		axi_rd(IRQ_STAT_OFS, v);
		chk(v, 32'h3);
		// Flag changes must keep the other bits of the word.
		op(5'h03, INT_CTRL_ADDR, 16'h0203);
		op(5'h11, INT_CTRL_ADDR, 16'h0);
		chk(int_val, 16'h0003);
		chk(irq_request, 0);
		op(5'h09, INT_CTRL_ADDR, 16'h0);
		chk(int_val, 16'h0203);
		// Controller interrupt: mask, raise, clear.
		chk(irq, 0);
		axi_wr(IRQ_MASK_OFS, 32'h1);
		repeat (2) @(posedge aclk);
		chk(irq, 1);
		axi_wr(IRQ_STAT_OFS, 32'h3);
		repeat (2) @(posedge aclk);
		chk(irq, 0);
		axi_rd(IRQ_STAT_OFS, v);
		chk(v, 32'h0);
		axi_rd(5'h1C, v);
		chk(v, 32'h0);
		// With the port off a write is ignored and never acknowledged.
		enable <= 0;
		axi_wr(WDATA_OFS, 32'h0);
		axi_wr(CTL_OFS, 32'h3 | (32'(rw_low) << CTL_LOWSEL_BIT));
		repeat (12) @(posedge aclk);
		chk(port.transfer_acknowledge_strobe_n, 1);
		chk(int_val, 16'h0203);
		axi_rd(STAT_OFS, v);
		chk(v[0], 1);
		aresetn <= 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		enable <= 1;
		@(posedge aclk);
		chk(int_val, INT_CTRL_RESET);
		tally_and_finish;
	end
endmodule : host_port_handshake_tb
